// ### verilog/adc_parallel_output_port.sv
// Result buffer and parallel output port of the sampling converter
`timescale 1ns/1ps

// Notes on behaviour
// - One sample taken each rising clock edge
// - Output enable low drives result pins
// - Output enable high releases all pins
// - Sleep request high suspends conversion
// - Sleep request low converts every cycle
// - Twelve pins, bit 0 least significant
// - Results coded in offset binary
// - Sustain one word per clock, both sides
// - Result appears six edges after sampling
// - Clamp below 0 and above 4095

// ----------------------------------------------------------------
// Word FIFO with valid and ready on both sides
// ----------------------------------------------------------------
module result_fifo #(
    parameter int WIDTH = 12,  // Word width
    parameter int DEPTH = 16   // Word count
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    logic [WIDTH-1:0] mem_reg  [DEPTH];  // Storage flops
    logic [WIDTH-1:0] mem_next [DEPTH];  // Storage next value
    logic [PTR_W-1:0] wr_ptr_reg;        // Next slot to fill
    logic [PTR_W-1:0] wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg;        // Oldest word
    logic [PTR_W-1:0] rd_ptr_next;
    logic [CNT_W-1:0] count_reg;         // Words held
    logic [CNT_W-1:0] count_next;
    logic             push;              // Word accepted
    logic             pop;               // Word removed

    // Honest flags from the word count
    assign in_ready_o  = (count_reg != CNT_FULL);
    assign out_valid_o = (count_reg != CNT_ZERO);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Pointer, count and storage next values
    always_comb begin
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_data_i;
            wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? PTR_ZERO
                                                   : wr_ptr_reg + PTR_ONE;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? PTR_ZERO
                                                   : rd_ptr_reg + PTR_ONE;
        end
        // Count moves only when one side acts alone
        if (push && !pop) begin
            count_next = count_reg + CNT_ONE;
        end else if (pop && !push) begin
            count_next = count_reg - CNT_ONE;
        end
    end

    // Register pointers and count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= PTR_ZERO;
            rd_ptr_reg <= PTR_ZERO;
            count_reg  <= CNT_ZERO;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // Register storage; contents are don't-care until written
    always_ff @(posedge clk_i) begin
        mem_reg <= mem_next;
    end

endmodule

// ----------------------------------------------------------------
// Converter digital core: sampler, pipeline, buffer, pin drivers
// ----------------------------------------------------------------
module adc_parallel_output_port
    import adc_port_pkg::*;
#(
    parameter int IN_W    = ANALOG_W,      // Modelled input width
    parameter int LATENCY = CONV_LATENCY,  // Edges to result
    parameter int DEPTH   = FIFO_DEPTH     // Buffer words
) (
    // Sample clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   RST_I,
    // Modelled differential input, signed, zero is mid-scale
    input  wire logic signed [IN_W-1:0] ANALOG_IN_I,
    // Control pins
    input  wire logic                   OUTPUT_EN_N_I,
    input  wire logic                   SLEEP_REQUEST_I,
    // Parallel result pins, enable low while driving
    output logic [RESULT_W-1:0]         SAMPLE_WORD_PINS_O,
    output logic [RESULT_W-1:0]         SAMPLE_WORD_PINS_OE_N_O,
    // Power mode status
    output logic                        ACTIVE_O
);

    // ------------------------------------------------------------
    // Constants of this instance
    // ------------------------------------------------------------
    // Pipeline stages before the buffer; buffer write and the
    // output register make up the remaining two edges
    localparam int PIPE_D = LATENCY - 1;
    localparam logic signed [IN_W:0] MID_EXT = (IN_W+1)'(CODE_MID);
    localparam logic signed [IN_W:0] MAX_EXT = (IN_W+1)'(CODE_MAX);
    localparam logic signed [IN_W:0] ZERO_EXT = '0;
    localparam sample_t SAMPLE_RST = '{valid: 1'b0, code: WORD_RST};

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    power_mode_t         mode_reg;            // Current power mode
    power_mode_t         mode_next;
    sample_t             stage_reg  [PIPE_D]; // Conversion pipeline
    sample_t             stage_next [PIPE_D];
    logic [RESULT_W-1:0] word_reg;            // Word on the pins
    logic [RESULT_W-1:0] word_next;
    logic [RESULT_W-1:0] oe_n_reg;            // Pin enables
    logic [RESULT_W-1:0] oe_n_next;
    logic                active_reg;          // Mode status flop
    logic                active_next;
    logic signed [IN_W:0] biased;             // Input plus offset
    logic [RESULT_W-1:0] clamped;             // Code after clamping
    logic                advance;             // Pipeline moves
    logic                fifo_in_ready;       // Buffer has room
    logic                fifo_out_valid;      // Buffer holds a word
    logic                fifo_out_ready;      // Pin stage takes word
    logic [RESULT_W-1:0] fifo_out_data;       // Oldest buffered word

    // ------------------------------------------------------------
    // Power mode
    // ------------------------------------------------------------
    // Mode follows the sleep request pin every edge
    always_comb begin
        mode_next = SLEEP_REQUEST_I ? MODE_SLEEP : MODE_ACTIVE;
        unique case (mode_next)
            MODE_ACTIVE: active_next = 1'b1;
            MODE_SLEEP:  active_next = 1'b0;
        endcase
    end

    // Register the mode
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_reg   <= MODE_SLEEP;
            active_reg <= 1'b0;
        end else begin
            mode_reg   <= mode_next;
            active_reg <= active_next;
        end
    end

    // ------------------------------------------------------------
    // Quantiser: offset binary with clamping
    // ------------------------------------------------------------
    // Shift the signed input by CODE_MID so input -2048 is code 0
    always_comb begin
        biased = $signed({ANALOG_IN_I[IN_W-1], ANALOG_IN_I}) + MID_EXT;
        if (biased < ZERO_EXT) begin
            clamped = CODE_MIN;
        end else if (biased > MAX_EXT) begin
            clamped = CODE_MAX;
        end else begin
            clamped = biased[RESULT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Conversion pipeline
    // ------------------------------------------------------------
    // Stalls in sleep and when the buffer cannot take a word, so
    // nothing in flight is ever dropped
    // sleep freezes conversion
    assign advance = (mode_reg == MODE_ACTIVE) && fifo_in_ready;

    // Stage 0 catches the sample; later stages shift it along
    genvar g;
    generate
        for (g = 0; g < PIPE_D; g++) begin : g_stage
            sample_t feed;  // Word offered to this stage

            // Head takes the new sample; no stage before it exists
            if (g == 0) begin : g_head
                assign feed = '{valid: 1'b1, code: clamped};
            end else begin : g_tail
                // Move sample one stage on
                assign feed = stage_reg[g-1];
            end

            // Next value of one stage: shift in or hold
            always_comb begin
                stage_next[g] = stage_reg[g];
                if (advance) begin
                    stage_next[g] = feed;
                end
            end

            // Register one stage
            always_ff @(posedge CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    stage_reg[g] <= SAMPLE_RST;
                end else begin
                    stage_reg[g] <= stage_next[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------
    // Pin stage drains one word per edge while active
    // one word per clock
    assign fifo_out_ready = (mode_reg == MODE_ACTIVE);

    // Buffer between the pipeline tail and the pin register
    result_fifo #(
        .WIDTH (RESULT_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i       (CLK_I),
        .rst_i       (RST_I),
        .in_valid_i  (advance && stage_reg[PIPE_D-1].valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (stage_reg[PIPE_D-1].code),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Next pin word: oldest buffered result, else hold the last
    always_comb begin
        word_next = word_reg;
        if (fifo_out_valid && fifo_out_ready) begin
            word_next = fifo_out_data;
        end
    end

    // Per-pin enable from the active-low output enable
    generate
        for (g = 0; g < RESULT_W; g++) begin : g_pin
            assign oe_n_next[g] = OUTPUT_EN_N_I;
        end
    endgenerate

    // Register pin word and enables
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            word_reg <= WORD_RST;
            oe_n_reg <= '1;
        end else begin
            word_reg <= word_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // bit 0 is the least significant pin
    assign SAMPLE_WORD_PINS_O      = word_reg;
    assign SAMPLE_WORD_PINS_OE_N_O = oe_n_reg;
    assign ACTIVE_O                = active_reg;

endmodule

// ### verilog/adc_port_pkg.sv
// Constants and types shared by the converter output port design
package adc_port_pkg;

    // ------------------------------------------------------------
    // Result word format
    // ------------------------------------------------------------
    localparam int          RESULT_W      = 12;       // Result pin count
    localparam logic [11:0] CODE_MIN      = 12'h000;  // Under-range code
    localparam logic [11:0] CODE_MAX      = 12'hFFF;  // Over-range code
    localparam logic [11:0] CODE_MID      = 12'h800;  // Offset for zero
    localparam logic [11:0] WORD_RST      = 12'h000;  // Pin word at reset

    // ------------------------------------------------------------
    // Pipeline and buffering
    // ------------------------------------------------------------
    localparam int          CONV_LATENCY  = 6;        // Edges to result
    localparam int          FIFO_DEPTH    = 16;       // Buffer words
    localparam int          ANALOG_W      = 14;       // Modelled input

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_PS = 5000;     // 200 MHz clock
    localparam int          MIN_RATE_MSPS = 40;       // Least throughput
    // Longest sample spacing allowed, rounded down to whole cycles
    localparam int          MAX_SPACING_CYC =
        (1000000 / MIN_RATE_MSPS) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Power mode of the converter
    typedef enum logic {
        MODE_ACTIVE,
        MODE_SLEEP
    } power_mode_t;

    // One conversion result travelling down the pipeline
    typedef struct packed {
        logic                valid;  // Stage holds a real sample
        logic [RESULT_W-1:0] code;   // Offset-binary result
    } sample_t;

endpackage

// ### verification/port_monitor.sv
// Checker of the converter output port pin behaviour
`timescale 1ns/1ps

module port_monitor
    import adc_port_pkg::*;
#(
    parameter int IN_W    = ANALOG_W,      // Modelled input width
    parameter int LATENCY = CONV_LATENCY,  // Edges to result
    parameter int DEPTH   = FIFO_DEPTH     // Buffer words
) (
    // Clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   RST_I,
    // Watched inputs
    input  wire logic signed [IN_W-1:0] ANALOG_IN_I,
    input  wire logic                   OUTPUT_EN_N_I,
    input  wire logic                   SLEEP_REQUEST_I,
    // Watched outputs
    input  wire logic [RESULT_W-1:0]    SAMPLE_WORD_PINS_O,
    input  wire logic [RESULT_W-1:0]    SAMPLE_WORD_PINS_OE_N_O,
    input  wire logic                   ACTIVE_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    // Pin code of an input, pinned at both ends of the range
    function automatic logic [RESULT_W-1:0] clamp_code(
        input logic signed [IN_W-1:0] v);
        int b;
        b = int'(v) + int'(CODE_MID);
        if (b < 0) return CODE_MIN;
        if (b > int'(CODE_MAX)) return CODE_MAX;
        return b[RESULT_W-1:0];
    endfunction

    // ----------------------------------------------------------------
    // Pin drivers and power mode
    // ----------------------------------------------------------------
    // Sampled reset keeps the release edge out: flops still held there
    AST_OE_DRIVE: assert property (
        !RST_I && !OUTPUT_EN_N_I |=> SAMPLE_WORD_PINS_OE_N_O == '0)
        else $error("Pins not driven after enable low");
    AST_OE_RELEASE: assert property (
        !RST_I && OUTPUT_EN_N_I |=> SAMPLE_WORD_PINS_OE_N_O == '1)
        else $error("Pins not released after enable high");
    AST_SLEEP_ENTER: assert property (
        !RST_I && SLEEP_REQUEST_I |=> !ACTIVE_O)
        else $error("Still active after sleep request");
    AST_SLEEP_LEAVE: assert property (
        !RST_I && !SLEEP_REQUEST_I |=> ACTIVE_O)
        else $error("Not active after sleep request dropped");
    AST_SLEEP_FREEZE: assert property (
        !ACTIVE_O |=> $stable(SAMPLE_WORD_PINS_O))
        else $error("Result word moved while asleep");

    // ----------------------------------------------------------------
    // Result path
    // ----------------------------------------------------------------
    AST_LATENCY: assert property (
        ACTIVE_O [*7] |=>
        SAMPLE_WORD_PINS_O == clamp_code($past(ANALOG_IN_I, 7)))
        else $error("Result word wrong six edges after sampling");
    AST_EVERY_CYCLE: assert property (
        ACTIVE_O [*8] ##0 (clamp_code($past(ANALOG_IN_I, 6)) !=
        clamp_code($past(ANALOG_IN_I, 7))) |=> $changed(SAMPLE_WORD_PINS_O))
        else $error("New result missing in a clock cycle");
    AST_CLAMP_TOP: assert property (
        ACTIVE_O [*7] ##0 ($past(ANALOG_IN_I, 6) > 14'sh07FF) |=>
        SAMPLE_WORD_PINS_O == CODE_MAX)
        else $error("Over range input not pinned to top code");
    AST_CLAMP_LOW: assert property (
        ACTIVE_O [*7] ##0 ($past(ANALOG_IN_I, 6) <= -14'sh0800) |=>
        SAMPLE_WORD_PINS_O == CODE_MIN)
        else $error("Under range input not pinned to bottom code");
endmodule

bind adc_parallel_output_port port_monitor #(
    .IN_W    (IN_W),
    .LATENCY (LATENCY),
    .DEPTH   (DEPTH)
) u_mon (
    .CLK_I                   (CLK_I),
    .RST_I                   (RST_I),
    .ANALOG_IN_I             (ANALOG_IN_I),
    .OUTPUT_EN_N_I           (OUTPUT_EN_N_I),
    .SLEEP_REQUEST_I         (SLEEP_REQUEST_I),
    .SAMPLE_WORD_PINS_O      (SAMPLE_WORD_PINS_O),
    .SAMPLE_WORD_PINS_OE_N_O (SAMPLE_WORD_PINS_OE_N_O),
    .ACTIVE_O                (ACTIVE_O)
);

// ### verification/capture_model.sv
// Capturing logic that registers the shared result bus
`timescale 1ns/1ps

module capture_model
    import adc_port_pkg::*;
(
    // Device clock
    input  wire logic                clk_i,
    // Result pins and their enables
    input  wire logic [RESULT_W-1:0] pins_i,
    input  wire logic [RESULT_W-1:0] oe_n_i,
    // Captured word and its qualifier
    output logic [RESULT_W-1:0]      word_o,
    output logic                     got_o
);
    logic [RESULT_W-1:0] last_reg = '0;  // Last level seen on the bus
    logic [RESULT_W-1:0] bus;            // Resolved bus level

    // Released bits flip each cycle so stale data never passes
    always_comb begin
        for (int i = 0; i < RESULT_W; i++) begin
            bus[i] = oe_n_i[i] ? ~last_reg[i] : pins_i[i];
        end
    end

    always_ff @(posedge clk_i) begin
        last_reg <= bus;
        word_o   <= bus;
        got_o    <= (oe_n_i == '0);
    end
endmodule

// ### verification/testbench.sv
// Self-checking bench of the converter output port
`timescale 1ns/1ps

module testbench
    import adc_port_pkg::*;
();
    logic               clk       = 1'b0;   // Sample clock
    logic               rst       = 1'b1;   // Reset
    logic signed [13:0] analog_in = '0;     // Modelled input
    logic               oe_n      = 1'b1;   // Output enable
    logic               sleep_req = 1'b0;   // Power down request
    logic [11:0]        pins;               // Result word
    logic [11:0]        pins_oe_n;          // Pin enables
    logic               active;             // Mode status
    logic [11:0]        cap_word;           // Word taken by host
    logic               cap_got;            // Host saw a driven bus
    int                 num_errors = 0;     // Mismatches
    int                 samples_checked = 0;
    int                 seed = 32'h5507;    // Random seed
    int                 cq[6];              // Reference pipeline codes
    bit                 vq[6];              // Reference stage valid
    int                 pins_m = 0;         // Reference word
    int                 prev_pins = 0;      // Word before the edge
    bit                 oe_m = 1'b1;        // Reference enable
    bit                 act_m = 1'b0;       // Reference mode
    // Inputs around both ends of the code range
    int                 edges[7] =
        '{-8192, -2049, -2048, 0, 2047, 2048, 8191};

    // ----------------------------------------------------------------
    // Clock, design and host
    // ----------------------------------------------------------------
    always #2.5 clk = ~clk;

    adc_parallel_output_port u_dut (
        .CLK_I                   (clk),
        .RST_I                   (rst),
        .ANALOG_IN_I             (analog_in),
        .OUTPUT_EN_N_I           (oe_n),
        .SLEEP_REQUEST_I         (sleep_req),
        .SAMPLE_WORD_PINS_O      (pins),
        .SAMPLE_WORD_PINS_OE_N_O (pins_oe_n),
        .ACTIVE_O                (active)
    );

    capture_model u_cap (
        .clk_i  (clk),
        .pins_i (pins),
        .oe_n_i (pins_oe_n),
        .word_o (cap_word),
        .got_o  (cap_got)
    );

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    function automatic int clamp_ref(input int v);
        int b;
        b = v + int'(CODE_MID);
        if (b < 0) return 0;
        if (b > int'(CODE_MAX)) return int'(CODE_MAX);
        return b;
    endfunction

    // Six-stage pipeline that freezes while asleep
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pins_m = 0;
            oe_m = 1'b1;
            act_m = 1'b0;
            vq = '{default: 1'b0};
        end else begin
            // Word before this edge, kept across a reset raised here
            prev_pins = pins_m;
            if (act_m) begin
                if (vq[5]) pins_m = cq[5];
                for (int i = 5; i > 0; i--) begin
                    vq[i] = vq[i-1];
                    cq[i] = cq[i-1];
                end
                vq[0] = 1'b1;
                cq[0] = clamp_ref(int'(analog_in));
            end
            act_m = !sleep_req;
            oe_m = oe_n;
        end
    end

    task automatic check(input string what, input logic [11:0] got,
                         input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Compare every result where outputs have settled
    always @(negedge clk) begin
        check("pins", pins, 12'(pins_m));
        check("enables", pins_oe_n, {12{oe_m}});
        check("active", {11'h000, active}, {11'h000, act_m});
        if (cap_got === 1'b1) check("capture", cap_word, 12'(prev_pins));
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    task automatic drive(input int n, input int slp, input int oe);
        logic [31:0] r;
        repeat (n) begin
            @(posedge clk);
            r = $random(seed);
            analog_in <= r[13:0];
            sleep_req <= (r[22:16] < slp);
            oe_n <= (r[30:24] < oe);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        oe_n <= 1'b0;
        foreach (edges[i]) begin
            @(posedge clk);
            analog_in <= 14'(edges[i]);
        end
        drive(200, 0, 0);
        $display("Test stream done");
        drive(200, 0, 64);
        $display("Test enable done");
        drive(300, 24, 16);
        drive(30, 128, 0);
        drive(40, 0, 0);
        $display("Test sleep done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        drive(100, 0, 0);
        $display("Test reset done");
        summarize();
    end

    // Watchdog well beyond the planned run
    initial begin
        #20000;
        num_errors++;
        $display("Watchdog expired");
        summarize();
    end
endmodule
